// File: include/ess_consts.vh
// constants for the emergency stop sequencer
`ifndef ESS_CONSTS_VH
`define ESS_CONSTS_VH

// clock and control cycle timing
`define ESS_CLK_MHZ 200
`define ESS_CTRL_CYCLE_US 1000
`define ESS_CTRL_CYCLE_CLKS (`ESS_CTRL_CYCLE_US * `ESS_CLK_MHZ)

// register bus geometry
`define ESS_ADDR_W 8
`define ESS_DATA_W 32
`define ESS_CNT_W 16

// register byte offsets and page numbers
`define ESS_OFS_STATUS 8'h00
`define ESS_OFS_ALARM 8'h04
`define ESS_PAGE_RAMP 4'h1
`define ESS_PAGE_DELAY 4'h2

// per-axis defaults, in control cycles
`define ESS_RAMP_RST 16'h0014
`define ESS_DELAY_RST 16'h0032

// alarm raised on entry to emergency stop
`define ESS_ALARM_NUM 16'h0BB8
`define ESS_ALARM_NONE 16'h0000

// status word field positions
`define ESS_ST_ACTIVE 0
`define ESS_ST_READY 1
`define ESS_ST_ALARM 2
`define ESS_ST_POSCTL 3
`define ESS_ST_ARMED 4
`define ESS_ST_IFEN 5
`define ESS_ST_DRV 8

`endif

// File: rtl/ess_sequencer.v
// emergency stop sequencer for the numeric control kernel
// Function
// - A set stop request starts the emergency stop sequence.
// - Entry interrupts the part program and brakes all axes on a ramp.
// - Entry clears the controller ready flag.
// - Entry sets the stop active flag.
// - Entry raises the dedicated emergency stop alarm number.
// - After per-axis delay the drive enable of that axis is withdrawn.
// - PLC digital outputs are left untouched by the sequence.
// - Without active stop, stop request or other alarm, interface signals act.
// - Exit needs acknowledge set, then reset set as well.
// - Exit clears active, restores drives, sets ready, aborts program.
// - Reset alone, without acknowledge, never ends emergency stop.
// - Power cycle cancels the stop unless the request is still set.
// - Button release alone neither ends the stop nor restarts.
// - Axis positions survive the stop; no re-referencing needed.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "ess_consts.vh"

module ess_sequencer #(
  parameter NUM_AXES = 4,
  parameter CYCLE_CLKS = `ESS_CTRL_CYCLE_CLKS
) (
  input wire clk_in,
  input wire rst_in,
  input wire estop_req_in,
  input wire estop_ack_in,
  input wire ctl_reset_in,
  input wire other_alarm_in,
  input wire [`ESS_ADDR_W-1:0] addr_in,
  input wire [`ESS_DATA_W-1:0] wr_data_in,
  input wire wr_in,
  input wire rd_in,
  output reg [`ESS_DATA_W-1:0] rd_data_out,
  output reg ready_out,
  output reg estop_active_out,
  output reg alarm_out,
  output reg [15:0] alarm_num_out,
  output reg pos_ctrl_active_out,
  output reg interface_enable_out,
  output reg prog_interrupt_out,
  output reg prog_abort_out,
  output wire [NUM_AXES-1:0] brake_out,
  output wire [NUM_AXES-1:0] drive_enable_out
);

  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_STOP = 2'b10;
  localparam CW = `ESS_CNT_W;

  // interface bits come from the PLC side, outside this clock
  reg req_meta_reg, req_sync_reg;
  reg ack_meta_reg, ack_sync_reg;
  reg rst_meta_reg, rst_sync_reg;
  reg oal_meta_reg, oal_sync_reg;

  always @(posedge clk_in) begin
    if (rst_in) begin
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
      oal_meta_reg <= 1'b0;
      oal_sync_reg <= 1'b0;
    end else begin
      req_meta_reg <= estop_req_in;
      req_sync_reg <= req_meta_reg;
      ack_meta_reg <= estop_ack_in;
      ack_sync_reg <= ack_meta_reg;
      rst_meta_reg <= ctl_reset_in;
      rst_sync_reg <= rst_meta_reg;
      oal_meta_reg <= other_alarm_in;
      oal_sync_reg <= oal_meta_reg;
    end
  end

  // control cycle divider: one-cycle tick
  reg [31:0] div_reg;
  reg tick_reg;

  always @(posedge clk_in) begin
    if (rst_in) begin
      div_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end else if (div_reg == CYCLE_CLKS - 1) begin
      div_reg <= 32'h0000_0000;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 32'h0000_0001;
      tick_reg <= 1'b0;
    end
  end

  // sequencer state
  reg [1:0] state_reg;
  reg armed_reg;
  wire enter_stop;
  wire leave_stop;

  // entry only on a sampled request; power-up with the request still
  // set simply re-enters at the first tick after reset
  assign enter_stop = tick_reg && state_reg == ST_RUN && req_sync_reg;
  // acknowledge must already have been seen on an earlier tick,
  // so reset alone or a simultaneous first edge does not release
  assign leave_stop = tick_reg && state_reg == ST_STOP && armed_reg &&
    ack_sync_reg && rst_sync_reg;

  always @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= ST_RUN;
      armed_reg <= 1'b0;
    end else if (tick_reg) begin
      case (state_reg)
        ST_RUN: begin
          armed_reg <= 1'b0;
          if (enter_stop)
            state_reg <= ST_STOP;
        end
        ST_STOP: begin
          armed_reg <= ack_sync_reg;
          if (leave_stop)
            state_reg <= ST_RUN;
        end
        default: begin
          state_reg <= ST_RUN;
          armed_reg <= 1'b0;
        end
      endcase
    end
  end

  // output flags; axis positions are never cleared here, so no
  // re-reference is needed after exit
  always @(posedge clk_in) begin
    if (rst_in) begin
      ready_out <= 1'b1;
      estop_active_out <= 1'b0;
      alarm_out <= 1'b0;
      alarm_num_out <= `ESS_ALARM_NONE;
      pos_ctrl_active_out <= 1'b1;
      interface_enable_out <= 1'b0;
      prog_interrupt_out <= 1'b0;
      prog_abort_out <= 1'b0;
    end else begin
      prog_interrupt_out <= enter_stop;
      prog_abort_out <= leave_stop;
      if (enter_stop) begin
        ready_out <= 1'b0;
        estop_active_out <= 1'b1;
        alarm_out <= 1'b1;
        alarm_num_out <= `ESS_ALARM_NUM;
      end else if (leave_stop) begin
        ready_out <= 1'b1;
        estop_active_out <= 1'b0;
        alarm_out <= 1'b0;
        alarm_num_out <= `ESS_ALARM_NONE;
        pos_ctrl_active_out <= 1'b1;
      end
      if (tick_reg)
        interface_enable_out <= state_reg == ST_RUN && !req_sync_reg &&
          !oal_sync_reg;
    end
  end

  // per-axis ramp and shutdown delay, in control cycles
  wire [NUM_AXES*CW-1:0] ramp_flat;
  wire [NUM_AXES*CW-1:0] delay_flat;
  wire page_ramp = addr_in[7:4] == `ESS_PAGE_RAMP;
  wire page_delay = addr_in[7:4] == `ESS_PAGE_DELAY;

  genvar g;
  generate
    for (g = 0; g < NUM_AXES; g = g + 1) begin : axis
      reg [CW-1:0] ramp_reg;
      reg [CW-1:0] delay_reg;
      reg [CW-1:0] cnt_reg;
      reg drv_reg;
      // axis slot within a page; four axes at most fit the address map
      localparam [1:0] AXIS_SEL = g;
      wire sel = addr_in[3:2] == AXIS_SEL;

      always @(posedge clk_in) begin
        if (rst_in) begin
          ramp_reg <= `ESS_RAMP_RST;
          delay_reg <= `ESS_DELAY_RST;
        end else if (wr_in && sel) begin
          if (page_ramp)
            ramp_reg <= wr_data_in[CW-1:0];
          else if (page_delay)
            delay_reg <= wr_data_in[CW-1:0];
        end
      end

      // counter holds at the delay once the drive is off
      always @(posedge clk_in) begin
        if (rst_in) begin
          cnt_reg <= {CW{1'b0}};
          drv_reg <= 1'b1;
        end else if (enter_stop || leave_stop) begin
          cnt_reg <= {CW{1'b0}};
          drv_reg <= 1'b1;
        end else if (tick_reg && state_reg == ST_STOP) begin
          if (cnt_reg >= delay_reg)
            drv_reg <= 1'b0;
          else
            cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
        end
      end

      // a delay shorter than the ramp cuts the drive mid-brake
      assign brake_out[g] = state_reg == ST_STOP && cnt_reg < ramp_reg &&
        drv_reg;
      assign drive_enable_out[g] = drv_reg;
      assign ramp_flat[g*CW +: CW] = ramp_reg;
      assign delay_flat[g*CW +: CW] = delay_reg;
    end
  endgenerate

  // register read: data one cycle after the strobe
  reg [`ESS_DATA_W-1:0] rd_next;
  reg [`ESS_DATA_W-1:0] status_word;
  integer idx;

  always @* begin
    status_word = {`ESS_DATA_W{1'b0}};
    status_word[`ESS_ST_ACTIVE] = estop_active_out;
    status_word[`ESS_ST_READY] = ready_out;
    status_word[`ESS_ST_ALARM] = alarm_out;
    status_word[`ESS_ST_POSCTL] = pos_ctrl_active_out;
    status_word[`ESS_ST_ARMED] = armed_reg;
    status_word[`ESS_ST_IFEN] = interface_enable_out;
    status_word[`ESS_ST_DRV +: NUM_AXES] = drive_enable_out;
  end

  always @* begin
    idx = {30'd0, addr_in[3:2]};
    rd_next = {`ESS_DATA_W{1'b0}};
    if (addr_in == `ESS_OFS_STATUS)
      rd_next = status_word;
    else if (addr_in == `ESS_OFS_ALARM)
      rd_next = {16'h0000, alarm_num_out};
    else if (page_ramp && idx < NUM_AXES && addr_in[1:0] == 2'b00)
      rd_next = {16'h0000, ramp_flat[idx*CW +: CW]};
    else if (page_delay && idx < NUM_AXES && addr_in[1:0] == 2'b00)
      rd_next = {16'h0000, delay_flat[idx*CW +: CW]};
  end

  // digital outputs of the PLC are not driven from here at all
  always @(posedge clk_in) begin
    if (rst_in)
      rd_data_out <= {`ESS_DATA_W{1'b0}};
    else if (rd_in)
      rd_data_out <= rd_next;
    else
      rd_data_out <= {`ESS_DATA_W{1'b0}};
  end

endmodule // ess_sequencer

// File: verification/ess_plc_model.sv
// plc user program model driving the stop interface bits
`timescale 1ns/1ps
module ess_plc_model (
  input wire clk_in,
  input wire button_in,
  input wire reset_key_in,
  output reg estop_req_out,
  output reg estop_ack_out,
  output reg ctl_reset_out
);
  initial begin
    estop_req_out = 1'b0;
    estop_ack_out = 1'b1;
    ctl_reset_out = 1'b0;
  end
  // ack is the released contact, so it falls whenever the button is in
  always @(posedge clk_in) begin
    estop_req_out <= button_in;
    estop_ack_out <= !button_in;
    ctl_reset_out <= reset_key_in;
  end
endmodule // ess_plc_model

// File: verification/ess_sequencer_properties.sv
// port checker for the emergency stop sequencer
`timescale 1ns/1ps
`include "ess_consts.vh"
module ess_sequencer_properties #(
  parameter NUM_AXES = 4,
  parameter CYCLE_CLKS = 8
) (
  input wire clk_in,
  input wire rst_in,
  input wire estop_req_in,
  input wire estop_ack_in,
  input wire ctl_reset_in,
  input wire rd_in,
  input wire [`ESS_DATA_W-1:0] rd_data_out,
  input wire ready_out,
  input wire estop_active_out,
  input wire alarm_out,
  input wire [15:0] alarm_num_out,
  input wire pos_ctrl_active_out,
  input wire prog_interrupt_out,
  input wire prog_abort_out,
  input wire [NUM_AXES-1:0] brake_out,
  input wire [NUM_AXES-1:0] drive_enable_out
);
  localparam [NUM_AXES-1:0] ALL = {NUM_AXES{1'b1}};
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  entry_flags_a: assert property ($rose(estop_active_out) |->
    !ready_out && alarm_out && alarm_num_out == `ESS_ALARM_NUM
    && prog_interrupt_out && brake_out == ALL) else $error("bad entry");
  exit_flags_a: assert property ($fell(estop_active_out) |->
    ready_out && !alarm_out && alarm_num_out == `ESS_ALARM_NONE
    && prog_abort_out && drive_enable_out == ALL && pos_ctrl_active_out)
    else $error("bad exit");
  // four cycles cover the two sync flops and the tick sample
  needs_ack_a: assert property ((!estop_ack_in) [*4] ##0
    estop_active_out |=> estop_active_out) else $error("exit without ack");
  needs_reset_a: assert property ((!ctl_reset_in) [*4] ##0
    estop_active_out |=> estop_active_out) else $error("exit w/o reset");
  no_cause_a: assert property ((!estop_req_in) [*4] ##0
    !estop_active_out |=> !estop_active_out) else $error("entry w/o req");
  entry_pulse_a: assert property (prog_interrupt_out |->
    $rose(estop_active_out) ##1 !prog_interrupt_out) else $error("int pulse");
  exit_pulse_a: assert property (prog_abort_out |->
    $fell(estop_active_out) ##1 !prog_abort_out) else $error("abort pulse");
  drives_held_a: assert property (!estop_active_out |->
    drive_enable_out == ALL && brake_out == '0) else $error("drive idle");
  rd_idle_a: assert property (!$past(rd_in) |-> rd_data_out == '0)
    else $error("read data stands");
  cover property ($rose(estop_active_out));
  cover property ($fell(estop_active_out));
  cover property (estop_active_out && drive_enable_out != ALL);
endmodule // ess_sequencer_properties
bind ess_sequencer ess_sequencer_properties #(.NUM_AXES(NUM_AXES),
  .CYCLE_CLKS(CYCLE_CLKS)) chk_u (.*);

// File: verification/tb_top.sv
// self-checking bench for the emergency stop sequencer
`timescale 1ns/1ps
module tb_top;
  reg clk_in = 0, rst_in = 1, button = 0, rkey = 0, oth = 0, wr = 0, rd = 0;
  reg [7:0] addr = 0;
  reg [31:0] wdata = 0;
  reg [3:0] mask;
  reg [39:0] rows [0:10];
  wire req, ack, crst, ready, active, alarm, posctl, ifen, pint, pabt;
  wire [31:0] rdata;
  wire [15:0] anum;
  wire [3:0] brake, drv;
  integer n_errors = 0, total_checks = 0, i, t;
  ess_plc_model plc_u (.clk_in(clk_in), .button_in(button),
    .reset_key_in(rkey), .estop_req_out(req), .estop_ack_out(ack),
    .ctl_reset_out(crst));
  ess_sequencer #(.NUM_AXES(4), .CYCLE_CLKS(8)) dut_u (.clk_in(clk_in),
    .rst_in(rst_in), .estop_req_in(req), .estop_ack_in(ack),
    .ctl_reset_in(crst), .other_alarm_in(oth), .addr_in(addr),
    .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .rd_data_out(rdata),
    .ready_out(ready), .estop_active_out(active), .alarm_out(alarm),
    .alarm_num_out(anum), .pos_ctrl_active_out(posctl),
    .interface_enable_out(ifen), .prog_interrupt_out(pint),
    .prog_abort_out(pabt), .brake_out(brake), .drive_enable_out(drv));
  initial forever #2.5 clk_in = !clk_in;
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task idle(input integer n);
    repeat (n) @(posedge clk_in);
  endtask
  task wr_reg(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
    end
  endtask
  task rd_chk(input [7:0] a, input [31:0] exp);
    begin
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      @(negedge clk_in) chk(rdata, exp);
      @(posedge clk_in);
    end
  endtask
  // bounded wait, ends on a rising edge so drivers stay edge aligned
  task wait_active(input v);
    begin
      t = 0;
      @(negedge clk_in);
      while (active !== v && t < 60) begin
        @(negedge clk_in);
        t = t + 1;
      end
      chk(active, v);
      @(posedge clk_in);
    end
  endtask
  task report_and_stop;
    begin
      $display("errors %0d checks %0d", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #20000;
    n_errors = n_errors + 1;
    report_and_stop;
  end
  initial begin
    for (i = 0; i < 4; i = i + 1) begin
      rows[i] = {8'h10 + 8'd4 * i[7:0], 32'h0000_0014};
      rows[i + 4] = {8'h20 + 8'd4 * i[7:0], 32'h0000_0032};
    end
    rows[8] = {8'h04, 32'h0000_0000};
    rows[9] = {8'h08, 32'h0000_0000};
    rows[10] = {8'h30, 32'h0000_0000};
    idle(12);
    rst_in <= 1'b0;
    idle(40);
    @(negedge clk_in) chk({ready, active, alarm, ifen}, 4'b1001);
    for (i = 0; i < 11; i = i + 1)
      rd_chk(rows[i][39:32], rows[i][31:0]);
    oth <= 1'b1;
    idle(40);
    @(negedge clk_in) chk(ifen, 1'b0);
    idle(1);
    oth <= 1'b0;
    // delays 2,5,8,11 ticks keep each axis drop window apart
    for (i = 0; i < 4; i = i + 1) begin
      wr_reg(8'h10 + 8'd4 * i[7:0], 32'h0000_0002);
      wr_reg(8'h20 + 8'd4 * i[7:0], 2 + 3 * i);
    end
    rd_chk(8'h2C, 32'h0000_000B);
    button <= 1'b1;
    wait_active(1'b1);
    chk({ready, alarm, anum}, {2'b01, 16'd3000});
    for (i = 0; i < 5; i = i + 1) begin
      mask = 4'hF << i;
      idle(i == 0 ? 5 : 24);
      @(negedge clk_in) chk(drv, mask);
      chk(brake, i == 0 ? 4'hF : 4'h0);
    end
    chk(ifen, 1'b0);
    // status: active, alarm, posctl set; ready, armed, ifen, drives low
    rd_chk(8'h00, 32'h0000_000D);
    rd_chk(8'h04, 32'h0000_0BB8);
    rkey <= 1'b1;
    idle(40);
    @(negedge clk_in) chk(active, 1'b1);
    idle(1);
    rkey <= 1'b0;
    button <= 1'b0;
    idle(40);
    @(negedge clk_in) chk(active, 1'b1);
    idle(1);
    rkey <= 1'b1;
    wait_active(1'b0);
    chk({ready, alarm, anum, drv, brake, posctl}, 27'h400_01E1);
    idle(20);
    rkey <= 1'b0;
    idle(40);
    @(negedge clk_in) chk({active, ifen}, 2'b01);
    idle(1);
    button <= 1'b1;
    wait_active(1'b1);
    rst_in <= 1'b1;
    idle(12);
    rst_in <= 1'b0;
    idle(2);
    @(negedge clk_in) chk(active, 1'b0);
    wait_active(1'b1);
    button <= 1'b0;
    rst_in <= 1'b1;
    idle(12);
    rst_in <= 1'b0;
    idle(40);
    @(negedge clk_in) chk({active, ready}, 2'b01);
    report_and_stop;
  end
endmodule // tb_top
